// [hw/agp_pkg.sv]
// register map, modes and reset values of the low address port
package agp_pkg;
    localparam int unsigned AW   = 20;
    localparam int unsigned PINS = 8;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0]   IDX_DIR = 16'hFFC0;
    localparam logic [15:0]   IDX_DAT = 16'hFFC2;
    localparam logic [15:0]   IDX_STS = 16'hFFC4;
    localparam logic [AW-1:0] ADR_DIR = {2'h0, IDX_DIR, 2'h0};
    localparam logic [AW-1:0] ADR_DAT = {2'h0, IDX_DAT, 2'h0};
    localparam logic [AW-1:0] ADR_STS = {2'h0, IDX_STS, 2'h0};

    // ------------------------------------------------------------
    // reset values and fixed read values
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RST   = 8'h00;
    localparam logic [7:0] DAT_RST   = 8'h00;
    localparam logic [7:0] PIN_RST   = 8'h00;
    localparam logic [7:0] DIR_FIXED = 8'hFF;
    localparam logic [7:0] DIR_READ  = 8'hFF;

    // ------------------------------------------------------------
    // operating modes and status fields
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_ADDR_FIRST = 3'h1;
    localparam logic [2:0]  MODE_ADDR_LAST  = 3'h4;
    localparam logic [2:0]  MODE_MIXED      = 3'h5;
    localparam int unsigned STS_MODE_LSB    = 0;
    localparam int unsigned STS_SWSTBY      = 4;
    localparam int unsigned STS_HWSTBY      = 5;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        FN_ADDR  = 3'h1,
        FN_MIXED = 3'h2,
        FN_GPIO  = 3'h4
    } agp_fn_t;
endpackage

// [hw/agp_regbus_if.sv]
// register strobe bundle between the bus front end and the port registers
`timescale 1ns/10ps
interface agp_regbus_if;
    logic                   wr_en;
    logic [agp_pkg::AW-1:0] wr_addr;
    logic [7:0]             wr_data;
    logic                   wr_strb;
    logic                   wr_err;
    logic                   rd_en;
    logic [agp_pkg::AW-1:0] rd_addr;
    logic [31:0]            rd_data;
    logic                   rd_err;
    modport slave_end (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                       input wr_err, rd_data, rd_err);
    modport regs_end (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                      output wr_err, rd_data, rd_err);
endinterface // agp_regbus_if

// [hw/agp_pin_cell.sv]
// one pin of the port: driver select and readback select
`timescale 1ns/10ps
module agp_pin_cell (
    input  wire logic addr_sel,
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic addr,
    input  wire logic pin_in,
    output logic      oe,
    output logic      out,
    output logic      rd
);
    always_comb begin
        oe  = dir;
        out = addr_sel ? addr : latch;
        rd  = dir ? latch : pin_in;
    end
endmodule // agp_pin_cell

// [hw/agp_axil_slave.sv]
// AXI4-Lite front end turning bus transfers into one-cycle register strobes
`timescale 1ns/10ps
module agp_axil_slave (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [agp_pkg::AW-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [agp_pkg::AW-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    agp_regbus_if.slave_end             rb
);
    typedef struct packed {
        logic                   aw_h;
        logic [agp_pkg::AW-1:0] aw_a;
        logic                   w_h;
        logic [7:0]             w_d;
        logic                   w_s;
        logic                   bv;
        logic [1:0]             br;
        logic                   rv;
        logic [31:0]            rd;
        logic [1:0]             rr;
    } agp_axs_t;

    agp_axs_t s_r;
    agp_axs_t s_nxt;

    always_comb begin
        awready    = !s_r.aw_h && !s_r.bv;
        wready     = !s_r.w_h && !s_r.bv;
        arready    = !s_r.rv;
        bvalid     = s_r.bv;
        bresp      = s_r.br;
        rvalid     = s_r.rv;
        rdata      = s_r.rd;
        rresp      = s_r.rr;
        rb.wr_en   = s_r.aw_h && s_r.w_h && !s_r.bv;
        rb.wr_addr = s_r.aw_a;
        rb.wr_data = s_r.w_d;
        rb.wr_strb = s_r.w_s;
        rb.rd_en   = arvalid && !s_r.rv;
        rb.rd_addr = araddr;
        s_nxt      = s_r;
        if (awvalid && awready) begin
            s_nxt.aw_h = 1'b1;
            s_nxt.aw_a = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_h = 1'b1;
            s_nxt.w_d = wdata[7:0];
            s_nxt.w_s = wstrb[0];
        end
        if (rb.wr_en) begin
            s_nxt.aw_h = 1'b0;
            s_nxt.w_h  = 1'b0;
            s_nxt.bv   = 1'b1;
            s_nxt.br   = rb.wr_err ? agp_pkg::RESP_SLVERR : agp_pkg::RESP_OKAY;
        end else if (s_r.bv && bready) begin
            s_nxt.bv = 1'b0;
        end
        if (rb.rd_en) begin
            s_nxt.rv = 1'b1;
            s_nxt.rd = rb.rd_data;
            s_nxt.rr = rb.rd_err ? agp_pkg::RESP_SLVERR : agp_pkg::RESP_OKAY;
        end else if (s_r.rv && rready) begin
            s_nxt.rv = 1'b0;
        end
        if (!aresetn) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end
endmodule // agp_axil_slave

// [hw/agp_port.sv]
// low address / general purpose port: registers, pin drivers and checks
`timescale 1ns/10ps
// Notes on behaviour
// - In modes 1 to 4 every pin drives its low address bit regardless of the registers.
// - In modes 1 to 4 the direction bits read as one and software writes do not change them.
// - In mode 5 a pin drives its address bit when its direction bit is one, else is an input.
// - In modes 6 and 7 a pin is a general output when its direction bit is one, else an input.
// - In modes 5 to 7 the direction register is write-only and reads back all ones.
// - Reset and hardware standby clear the direction register; modes 1 to 4 see all ones.
// - Software standby keeps the direction register and keeps driving every output pin.
// - A data read returns the latch bit for each pin whose direction bit is one.
// - A data read returns the sampled pin level for each pin whose direction bit is zero.
// - Reset and hardware standby clear the data latch; software standby keeps it.
// - The data latch holds the values driven on pins used as general outputs.
// - In mode 5 all pins leave reset as inputs since the direction bits reset to zero.
module agp_port (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [agp_pkg::AW-1:0]    awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [agp_pkg::AW-1:0]    araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic [2:0]                op_mode,
    input  wire logic                      hw_standby,
    input  wire logic                      sw_standby,
    input  wire logic [agp_pkg::PINS-1:0]  low_address_outputs,
    input  wire logic [agp_pkg::PINS-1:0]  pin_in,
    output logic [agp_pkg::PINS-1:0]       pin_out,
    output logic [agp_pkg::PINS-1:0]       pin_oe
);
    localparam int unsigned N = agp_pkg::PINS;

    typedef struct packed {
        logic [N-1:0] dir;
        logic [N-1:0] latch;
        logic [N-1:0] pout;
        logic [N-1:0] poe;
    } agp_port_t;

    agp_port_t        s_r;
    agp_port_t        s_nxt;
    agp_pkg::agp_fn_t fn;
    logic [N-1:0]     dir_eff;
    logic [N-1:0]     cell_oe;
    logic [N-1:0]     cell_out;
    logic [N-1:0]     cell_rd;
    logic [N-1:0]     exp_rd;
    logic [7:0]       sts;
    logic [7:0]       rd_byte;
    logic             hit_dir_w;
    logic             hit_dat_w;
    logic             hit_sts_w;
    logic             hit_dir_r;
    logic             hit_dat_r;
    logic             hit_sts_r;
    logic             live;

    agp_regbus_if rb();

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    agp_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rb      (rb)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb begin
        if (op_mode >= agp_pkg::MODE_ADDR_FIRST && op_mode <= agp_pkg::MODE_ADDR_LAST) begin
            fn = agp_pkg::FN_ADDR;
        end else if (op_mode == agp_pkg::MODE_MIXED) begin
            fn = agp_pkg::FN_MIXED;
        end else begin
            fn = agp_pkg::FN_GPIO;
        end
        case (fn)
            agp_pkg::FN_ADDR: begin
                dir_eff = agp_pkg::DIR_FIXED;
            end
            agp_pkg::FN_MIXED: begin
                dir_eff = s_r.dir;
            end
            agp_pkg::FN_GPIO: begin
                dir_eff = s_r.dir;
            end
            default: begin
                dir_eff = s_r.dir;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin cells
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_pin
        agp_pin_cell u_cell (
            .addr_sel (fn != agp_pkg::FN_GPIO),
            .dir      (dir_eff[i]),
            .latch    (s_r.latch[i]),
            .addr     (low_address_outputs[i]),
            .pin_in   (pin_in[i]),
            .oe       (cell_oe[i]),
            .out      (cell_out[i]),
            .rd       (cell_rd[i])
        );
    end

    // ------------------------------------------------------------
    // address decode and read mux
    // ------------------------------------------------------------
    always_comb begin
        live      = !sw_standby;
        hit_dir_w = rb.wr_addr[agp_pkg::AW-1:2] == agp_pkg::ADR_DIR[agp_pkg::AW-1:2];
        hit_dat_w = rb.wr_addr[agp_pkg::AW-1:2] == agp_pkg::ADR_DAT[agp_pkg::AW-1:2];
        hit_sts_w = rb.wr_addr[agp_pkg::AW-1:2] == agp_pkg::ADR_STS[agp_pkg::AW-1:2];
        hit_dir_r = rb.rd_addr[agp_pkg::AW-1:2] == agp_pkg::ADR_DIR[agp_pkg::AW-1:2];
        hit_dat_r = rb.rd_addr[agp_pkg::AW-1:2] == agp_pkg::ADR_DAT[agp_pkg::AW-1:2];
        hit_sts_r = rb.rd_addr[agp_pkg::AW-1:2] == agp_pkg::ADR_STS[agp_pkg::AW-1:2];
        rb.wr_err = !(hit_dir_w || hit_dat_w || hit_sts_w);
        rb.rd_err = !(hit_dir_r || hit_dat_r || hit_sts_r);
        sts = 8'h00;
        sts[agp_pkg::STS_MODE_LSB +: 3] = op_mode;
        sts[agp_pkg::STS_SWSTBY] = sw_standby;
        sts[agp_pkg::STS_HWSTBY] = hw_standby;
        if (hit_dir_r) begin
            rd_byte = agp_pkg::DIR_READ;
        end else if (hit_dat_r) begin
            rd_byte = cell_rd;
        end else if (hit_sts_r) begin
            rd_byte = sts;
        end else begin
            rd_byte = 8'h00;
        end
        rb.rd_data = {24'h000000, rd_byte};
    end

    // ------------------------------------------------------------
    // registers and pin drivers
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // software standby freezes the registers, the bus still answers
        if (rb.wr_en && rb.wr_strb && live) begin
            if (hit_dir_w && fn != agp_pkg::FN_ADDR) begin
                s_nxt.dir = rb.wr_data;
            end
            if (hit_dat_w) begin
                s_nxt.latch = rb.wr_data;
            end
        end
        if (live) begin
            s_nxt.pout = cell_out;
            s_nxt.poe  = cell_oe;
        end
        if (hw_standby) begin
            s_nxt.dir   = agp_pkg::DIR_RST;
            s_nxt.latch = agp_pkg::DAT_RST;
        end
        if (!aresetn) begin
            s_nxt.dir   = agp_pkg::DIR_RST;
            s_nxt.latch = agp_pkg::DAT_RST;
            s_nxt.pout  = agp_pkg::PIN_RST;
            s_nxt.poe   = agp_pkg::PIN_RST;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    always_comb begin
        pin_out = s_r.pout;
        pin_oe  = s_r.poe;
        exp_rd  = (dir_eff & s_r.latch) | (~dir_eff & pin_in);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_dat_wr;
        rb.wr_en && rb.wr_strb && hit_dat_w && live && !hw_standby && fn == agp_pkg::FN_GPIO;
    endsequence

    sequence s_dir_wr;
        rb.wr_en && rb.wr_strb && hit_dir_w && live && !hw_standby && fn == agp_pkg::FN_GPIO;
    endsequence

    sequence s_settle;
        live && !hw_standby && !rb.wr_en && fn == agp_pkg::FN_GPIO;
    endsequence

    addr_mode_pins_a: assert property (
        fn == agp_pkg::FN_ADDR && live
        |=> pin_oe == agp_pkg::DIR_FIXED && pin_out == $past(low_address_outputs))
        else $error("address mode pin not driving address");

    fixed_dir_write_a: assert property (
        rb.wr_en && hit_dir_w && fn == agp_pkg::FN_ADDR && !hw_standby
        |=> s_r.dir == $past(s_r.dir))
        else $error("direction changed by write in address mode");

    mixed_mode_pins_a: assert property (
        fn == agp_pkg::FN_MIXED && live
        |=> pin_oe == $past(s_r.dir)
            && (pin_out & pin_oe) == ($past(low_address_outputs) & pin_oe))
        else $error("mixed mode pin wrong");

    gpio_mode_pins_a: assert property (
        fn == agp_pkg::FN_GPIO && live
        |=> pin_oe == $past(s_r.dir) && (pin_out & pin_oe) == ($past(s_r.latch) & pin_oe))
        else $error("general mode pin wrong");

    dir_read_ones_a: assert property (
        rb.rd_en && hit_dir_r
        |=> rvalid && rresp == agp_pkg::RESP_OKAY
            && rdata == {24'h000000, agp_pkg::DIR_READ})
        else $error("direction read not all ones");

    reset_clear_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn || hw_standby
        |=> s_r.dir == agp_pkg::DIR_RST && s_r.latch == agp_pkg::DAT_RST)
        else $error("reset did not clear registers");

    sw_standby_hold_a: assert property (
        sw_standby && !hw_standby
        |=> $stable(pin_out) && $stable(pin_oe) && $stable(s_r.dir) && $stable(s_r.latch))
        else $error("state moved in software standby");

    data_read_mux_a: assert property (
        rb.rd_en && hit_dat_r
        |=> rvalid && rdata[7:0] == $past(exp_rd))
        else $error("data read mux wrong");

    latch_to_pin_a: assert property (
        s_dat_wr ##1 s_settle
        |=> (pin_out & pin_oe) == (s_r.latch & pin_oe) && s_r.latch == $past(rb.wr_data, 2))
        else $error("latch write did not reach pins");

    dir_to_pin_a: assert property (
        s_dir_wr ##1 s_settle |=> pin_oe == $past(rb.wr_data, 2))
        else $error("direction write did not reach pins");

    mixed_reset_in_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        $rose(aresetn) && fn == agp_pkg::FN_MIXED
        |-> pin_oe == agp_pkg::PIN_RST ##1 pin_oe == agp_pkg::PIN_RST)
        else $error("mixed mode pin left reset as output");
endmodule // agp_port

// [testbench/agp_board_model.sv]
// board logic model sitting on the port pins
`timescale 1ns/10ps
module agp_board_model (
    input  wire logic [agp_pkg::PINS-1:0] pin_out,
    input  wire logic [agp_pkg::PINS-1:0] pin_oe,
    input  wire logic [agp_pkg::PINS-1:0] ext_val,
    output logic      [agp_pkg::PINS-1:0] pin_in
);
    // --------------------------------------------------------
    // wire level: device where it drives, board elsewhere
    // --------------------------------------------------------
    always_comb begin
        for (int i = 0; i < agp_pkg::PINS; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
        end
    end
endmodule // agp_board_model

// [testbench/tb_top.sv]
// self-checking bench of the low address port
`timescale 1ns/10ps
module tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, hw_standby, sw_standby;
    logic [19:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  op_mode, m;
    logic [7:0]  addr_lo, pin_in, pin_out, pin_oe, ext_val, d, l, e;
    int          bad_count, n_tests;

    agp_port DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .op_mode(op_mode), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .low_address_outputs(addr_lo), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    agp_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .pin_in(pin_in));

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] f_oe(input logic [2:0] md, input logic [7:0] dr);
        return (md >= agp_pkg::MODE_ADDR_FIRST && md <= agp_pkg::MODE_ADDR_LAST) ? 8'hFF : dr;
    endfunction
    function automatic logic [7:0] f_out(input logic [2:0] md, input logic [7:0] lt,
                                         input logic [7:0] ad);
        return (md >= agp_pkg::MODE_ADDR_FIRST && md <= agp_pkg::MODE_MIXED) ? ad : lt;
    endfunction
    function automatic logic [31:0] f_rd(input logic [2:0] md, input logic [7:0] dr,
                                         input logic [7:0] lt, input logic [7:0] ex);
        logic [7:0] de;
        de = f_oe(md, dr);
        return {24'h0, (de & lt) | (~de & ex)};
    endfunction

    // ------------------------------------------------------------
    // checks, bus cycles, end of run
    // ------------------------------------------------------------
    task automatic fail(input string s);
        bad_count++;
        $display("MISMATCH %0t %s", $time, s);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string s);
        n_tests++;
        if (g !== x) begin
            fail($sformatf("%s got %h exp %h", s, g, x));
        end
    endtask
    task automatic pins(input logic [7:0] dr, input logic [7:0] lt);
        chk({24'h0, pin_oe}, {24'h0, f_oe(m, dr)}, "pin enables");
        chk({24'h0, pin_out & f_oe(m, dr)}, {24'h0, f_out(m, lt, addr_lo) & f_oe(m, dr)},
            "pin values");
    endtask
    task automatic wrreg(input logic [19:0] a, input logic [7:0] dt, output logic [1:0] r);
        int t;
        t = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, dt};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && t < 100);
        r = bresp;
        bready <= 1'h0;
        if (t >= 100) fail("write hang");
    endtask
    task automatic rdreg(input logic [19:0] a, output logic [31:0] dt, output logic [1:0] r);
        int t;
        t = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge aclk);
            t++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && t < 100);
        dt = rdata;
        r = rresp;
        rready <= 1'h0;
        if (t >= 100) fail("read hang");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        #(25 * 20000);
        fail("watchdog");
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, sw_standby} = 8'h00;
        {awaddr, araddr, wdata, addr_lo, ext_val} = '0;
        wstrb = 4'hF;
        m = agp_pkg::MODE_MIXED;
        op_mode = m;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(32'h1fb5ec62));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        ext_val <= 8'($urandom);
        repeat (2) @(posedge aclk);
        #1 pins(8'h00, 8'h00);
        rdreg(agp_pkg::ADR_DIR, rd, resp);
        chk(rd, 32'hFF, "dir read mixed");
        rdreg(agp_pkg::ADR_DAT, rd, resp);
        chk(rd, {24'h0, ext_val}, "pin level read");
        for (int k = 1; k <= 4; k++) begin
            m = k[2:0];
            @(posedge aclk);
            op_mode <= m;
            wrreg(agp_pkg::ADR_DIR, 8'h5A, resp);
            for (int j = 0; j < 6; j++) begin
                e = 8'($urandom);
                @(posedge aclk);
                addr_lo <= e;
                @(posedge aclk);
                #1 chk({24'h0, pin_out}, {24'h0, e}, "address follow");
            end
            chk({24'h0, pin_oe}, 32'hFF, "fixed enables");
            rdreg(agp_pkg::ADR_DIR, rd, resp);
            chk(rd, 32'hFF, "fixed dir read");
        end
        for (int i = 0; i < 24; i++) begin
            m = (i % 4 == 0) ? 3'h0 : agp_pkg::MODE_MIXED + 3'(i % 4 - 1);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            l = 8'($urandom);
            @(posedge aclk);
            op_mode <= m;
            ext_val <= 8'($urandom);
            addr_lo <= 8'($urandom);
            wrreg(agp_pkg::ADR_DIR, d, resp);
            wrreg(agp_pkg::ADR_DAT, l, resp);
            #1 pins(d, l);
            chk({30'h0, resp}, {30'h0, agp_pkg::RESP_OKAY}, "write okay");
            rdreg(agp_pkg::ADR_DAT, rd, resp);
            chk(rd, f_rd(m, d, l, ext_val), "data read");
            chk({30'h0, resp}, {30'h0, agp_pkg::RESP_OKAY}, "read okay");
            rdreg(agp_pkg::ADR_DIR, rd, resp);
            chk(rd, 32'hFF, "dir read");
        end
        @(posedge aclk);
        sw_standby <= 1'h1;
        wrreg(agp_pkg::ADR_DIR, ~d, resp);
        wrreg(agp_pkg::ADR_DAT, ~l, resp);
        #1 pins(d, l);
        rdreg(agp_pkg::ADR_STS, rd, resp);
        chk(rd, (32'(m) << agp_pkg::STS_MODE_LSB) | (32'h1 << agp_pkg::STS_SWSTBY),
            "status read");
        @(posedge aclk);
        sw_standby <= 1'h0;
        wstrb <= 4'hE;
        wrreg(agp_pkg::ADR_DAT, ~l, resp);
        rdreg(agp_pkg::ADR_DAT, rd, resp);
        wstrb <= 4'hF;
        chk(rd, f_rd(m, d, l, ext_val), "standby kept data");
        for (int k = 0; k < 2; k++) begin
            wrreg(agp_pkg::ADR_DAT, 8'hA5, resp);
            @(posedge aclk);
            if (k == 0) hw_standby <= 1'h1;
            else aresetn <= 1'h0;
            repeat (5) @(posedge aclk);
            hw_standby <= 1'h0;
            aresetn <= 1'h1;
            repeat (2) @(posedge aclk);
            #1 chk({24'h0, pin_oe}, {24'h0, f_oe(m, 8'h00)}, "dir cleared");
            wrreg(agp_pkg::ADR_DIR, 8'hFF, resp);
            rdreg(agp_pkg::ADR_DAT, rd, resp);
            chk(rd, 32'h0, "latch cleared");
        end
        wrreg(20'h00100, 8'h5A, resp);
        chk({30'h0, resp}, {30'h0, agp_pkg::RESP_SLVERR}, "unmapped write");
        rdreg(20'h00100, rd, resp);
        chk({30'h0, resp}, {30'h0, agp_pkg::RESP_SLVERR}, "unmapped read");
        tally_and_finish();
    end
endmodule // tb_top
